/* File: shared/curtain_defs.svh */
// constants for the receiver segment check and fixed blanking evaluator
// assumes a 50 MHz core clock; included by the package and the rtl
`ifndef CURTAIN_DEFS_SVH
`define CURTAIN_DEFS_SVH

`define BEAMS 256
`define SEGS 4
`define MASTER_MAX 10'h0b4
`define SLAVE_MAX 10'h080
`define TOTAL_MAX 10'h100
`define SEG_MAX 3'h4
`define CODE_NONE 8'h00
`define CODE_SIZE 8'h01
`define CODE_FLEX 8'h5f
`define CODE_REDUCED 8'h64
`define ADDR_CONFIG 4'h0
`define ADDR_COMMAND 4'h4
`define ADDR_STATUS 4'h8
`define ADDR_SEGMENTS 4'hc
`define CFG_W 6
`define CMD_PROGRAM 0
`define CMD_FINISH 1
`define CFG_RESET 6'h00
`define CLK_KHZ 50000
`define FLASH_HOLD_MS 3000
`define RELEASE_MS 2000
`define BLINK_MS 167

`endif

/* File: shared/curtain_pkg.sv */
// types shared by the segment check and fixed blanking evaluator
// assumes curtain_defs.svh is reachable on the include path
package curtain_pkg;
  `include "curtain_defs.svh"

  typedef enum logic [2:0] {
    ST_POWER = 3'b000,
    ST_STOP = 3'b001,
    ST_INTERLOCK = 3'b010,
    ST_RUN = 3'b011,
    ST_ALARM = 3'b100,
    ST_CONFIG = 3'b101,
    ST_HOLD = 3'b110
  } op_state_e;

  typedef enum logic [1:0] {
    MODE_AUTO = 2'b00,
    MODE_START = 2'b01,
    MODE_START_ILK = 2'b10,
    MODE_RESTART_ILK = 2'b11
  } start_mode_e;

  typedef struct packed {
    logic [2:0] seg_count;
    start_mode_e mode;
    logic blank_en;
  } cfg_s;

  typedef struct packed {
    logic red;
    logic green;
    logic yellow;
    logic amber;
  } leds_s;
endpackage

/* File: rtl/blank_area_check.sv */
// per-beam comparison of live beams against the stored blanking pattern
// assumes pattern bit 0 is the beam nearest the entry end; purely combinational
`timescale 1ns/1ps
`include "curtain_defs.svh"
module blank_area_check
  import curtain_pkg::*;
(
  input wire logic [`BEAMS-1:0] pattern_in,
  input wire logic [`BEAMS-1:0] live_in,
  input wire logic [2:0][9:0] bound_in,
  output logic match_out,
  output logic span_err_out
);
  logic [`BEAMS+3:0] pp;
  logic [`BEAMS+3:0] ll;
  logic [`BEAMS+3:0] dn;
  logic [`BEAMS-1:0] ok;
  logic [`BEAMS-1:0] span;

  assign pp = {2'b00, pattern_in, 2'b00};
  assign ll = {2'b00, live_in, 2'b00};
  assign dn[1:0] = 2'b00;
  assign dn[`BEAMS+3:`BEAMS+2] = 2'b00;

  genvar i;
  generate
    for (i = 0; i < `BEAMS; i = i + 1) begin : g_beam
      wire logic first;
      wire logic lo;
      wire logic hi;
      wire logic hi2;
      wire logic lo2;
      wire logic inner;
      wire logic single;
      wire logic edge_ok;
      wire logic grow_ok;
      assign first = (10'(i) == bound_in[0]) || (10'(i) == bound_in[1]) ||
        (10'(i) == bound_in[2]);
      // link to the lower neighbour only inside one segment
      assign dn[i+2] = (i != 0) && !first;
      assign lo = pp[i+1] & dn[i+2];
      assign hi = pp[i+3] & dn[i+3];
      assign lo2 = pp[i] & dn[i+2] & dn[i+1];
      assign hi2 = pp[i+4] & dn[i+3] & dn[i+4];
      assign inner = lo & hi;
      assign single = !lo && !hi;
      // an edge may clear only while its neighbour in the area holds
      assign edge_ok = lo ? ll[i+1] : ll[i+3];
      // growth by one beam, never into a one-beam gap nor filling both beams of a two-beam gap
      assign grow_ok = (lo ^ hi) && !(lo && hi2 && ll[i+3]) &&
        !(hi && lo2 && ll[i+1]);
      always_comb begin
        if (pp[i+2]) begin
          ok[i] = ll[i+2] || (!inner && !single && edge_ok);
        end else begin
          ok[i] = !ll[i+2] || grow_ok;
        end
      end
      assign span[i] = ll[i+2] & ll[i+1] & first & (i != 0);
    end
  endgenerate

  assign match_out = &ok;
  assign span_err_out = |span;
endmodule

/* File: rtl/curtain_eval.sv */
// receiver evaluation: segment size check, segment loss faults, fixed blanking
// assumes synchronous inputs, power-up is sys_rst_in; nv_init_in seeds the
// stored configuration and pattern, which survive sys_rst_in like flash memory
`timescale 1ns/1ps
`include "curtain_defs.svh"
// Contract
// - master above 180 beams or system above 256 beams is invalid
// - any slave segment above 128 beams is invalid
// - at most four chained segments including the first
// - segment count drop while powered gives fault code 95
// - after power cycle or unpowered removal report fault code 100
// - code 100 clears when configuration is read then reduced size written
// - start held at power-up flashes red, yellow, amber about three seconds
// - transmitter never faults on reduction but must match receiver counts
// - only one stored blanking pattern drives detection
// - recorded blocked beams stay blocked, recorded clear beams stay clear
// - areas separated by a clear beam, never across segment boundary
// - areas of two or more allow one beam change at edges
// - gaps of one or two beams may not be closed by tolerance
// - one-beam gap is never used by the area nearer entry end
// - one-beam area stays blocked, may grow to two, never vanish
// - fixed blanking works in every start mode
// - capture only in stop or config state with blanking enabled on program command
// - disabling fixed blanking erases the stored pattern
// - enabling blanking enters config state; program flashes; finish restarts
// - run state drives both safety outputs on and green lit
// - alarm holds outputs off, yellow flashes, persists until cause cleared
// - after programming restart, matching beams lead to interlock or run
module curtain_eval
  import curtain_pkg::*;
#(
  parameter int unsigned FLASH_CYCLES = `FLASH_HOLD_MS * `CLK_KHZ,
  parameter int unsigned RELEASE_CYCLES = `RELEASE_MS * `CLK_KHZ,
  parameter int unsigned BLINK_CYCLES = `BLINK_MS * `CLK_KHZ
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic nv_init_in,
  input wire logic [`BEAMS-1:0] beams_blocked_in,
  input wire logic [2:0] seg_count_in,
  input wire logic [3:0][7:0] seg_beams_in,
  input wire logic start_in,
  input wire logic [3:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rd_data_out,
  output logic [1:0] safety_output_pair_out,
  output logic aux_out,
  output leds_s leds_out,
  output logic [`BEAMS-1:0] beam_indicator_lamps_out,
  output logic [7:0] fault_code_out
);
  op_state_e state;
  op_state_e next_state;
  cfg_s cfg;
  cfg_s next_cfg;
  cfg_s wr_cfg;
  logic [`BEAMS-1:0] pattern;
  logic [`BEAMS-1:0] next_pattern;
  logic pat_valid;
  logic next_pat_valid;
  logic seg_lost;
  logic next_seg_lost;
  logic [7:0] code;
  logic [7:0] next_code;
  logic [27:0] timer;
  logic [27:0] next_timer;
  logic hold_seen;
  logic next_hold_seen;
  logic cfg_loaded;
  logic next_cfg_loaded;
  logic prog_flash;
  logic next_prog_flash;
  logic start_prev;
  logic [23:0] blink_cnt;
  logic blink;
  logic [31:0] rd_mux;

  // size checks on the reported segment lengths
  wire logic [9:0] total_beams;
  wire logic [2:0][9:0] bounds;
  wire logic master_big;
  wire logic slave_big;
  wire logic total_big;
  wire logic count_bad;
  wire logic cfg_invalid;
  assign bounds[0] = {2'b00, seg_beams_in[0]};
  assign bounds[1] = bounds[0] + {2'b00, seg_beams_in[1]};
  assign bounds[2] = bounds[1] + {2'b00, seg_beams_in[2]};
  assign total_beams = bounds[2] + {2'b00, seg_beams_in[3]};
  assign master_big = {2'b00, seg_beams_in[0]} > `MASTER_MAX;
  assign total_big = total_beams > `TOTAL_MAX;
  assign slave_big = ({2'b00, seg_beams_in[1]} > `SLAVE_MAX) ||
    ({2'b00, seg_beams_in[2]} > `SLAVE_MAX) ||
    ({2'b00, seg_beams_in[3]} > `SLAVE_MAX);
  assign count_bad = (seg_count_in > `SEG_MAX) || (seg_count_in == 3'h0);
  assign cfg_invalid = master_big || slave_big || total_big || count_bad;

  // segment loss compares live count with the stored configuration
  wire logic seg_short;
  wire logic running;
  assign seg_short = seg_count_in < cfg.seg_count;
  // an alarm already raised keeps its code, so a reduced chain seen at power-up
  // stays reported as reduced instead of turning into the powered-loss code
  assign running = (state != ST_POWER) && (state != ST_HOLD) &&
    (state != ST_ALARM);

  wire logic pat_match;
  wire logic span_err;
  wire logic blank_on;
  wire logic zone_ok;
  blank_area_check u_check (
    .pattern_in(pattern),
    .live_in(beams_blocked_in),
    .bound_in(bounds),
    .match_out(pat_match),
    .span_err_out(span_err)
  );
  assign blank_on = cfg.blank_en && pat_valid;
  // one stored pattern, or an empty zone when blanking is off or no pattern is stored
  assign zone_ok = blank_on ? pat_match : ~|beams_blocked_in;

  // register port decode
  wire logic wr_config;
  wire logic wr_command;
  wire logic rd_config;
  wire logic do_program;
  wire logic do_finish;
  wire logic start_release;
  assign wr_config = wr_in && (addr_in == `ADDR_CONFIG);
  assign wr_command = wr_in && (addr_in == `ADDR_COMMAND);
  assign rd_config = rd_in && (addr_in == `ADDR_CONFIG);
  assign wr_cfg = cfg_s'(wr_data_in[`CFG_W-1:0]);
  assign do_program = wr_command && wr_data_in[`CMD_PROGRAM];
  assign do_finish = wr_command && wr_data_in[`CMD_FINISH];
  assign start_release = start_prev && !start_in;

  // read words; unused bits read as zero
  always_comb begin
    if (addr_in == `ADDR_CONFIG) begin
      rd_mux = {26'h0000000, cfg};
    end else if (addr_in == `ADDR_STATUS) begin
      rd_mux = {12'h000, prog_flash, seg_lost, pat_valid, zone_ok, code, 5'h00, state};
    end else if (addr_in == `ADDR_SEGMENTS) begin
      rd_mux = {15'h0000, cfg_invalid, 1'b0, seg_count_in, 2'h0, total_beams};
    end else begin
      rd_mux = 32'h00000000;
    end
  end

  always_comb begin
    next_state = state;
    next_cfg = cfg;
    next_pattern = pattern;
    next_pat_valid = pat_valid;
    next_seg_lost = seg_lost;
    next_code = code;
    next_timer = timer;
    next_hold_seen = hold_seen;
    next_cfg_loaded = cfg_loaded || rd_config;
    next_prog_flash = prog_flash;
    case (state)
      ST_POWER: begin
        next_prog_flash = 1'b0;
        if (start_in && !hold_seen) begin
          next_state = ST_HOLD;
          next_hold_seen = 1'b1;
          next_timer = 28'h0000000;
        end else if (cfg_invalid) begin
          next_state = ST_ALARM;
          next_code = `CODE_SIZE;
        end else if (seg_lost || seg_short) begin
          next_state = ST_ALARM;
          next_code = `CODE_REDUCED;
          next_seg_lost = 1'b1;
        end else if (!zone_ok) begin
          next_state = ST_STOP;
        end else if (cfg.mode == MODE_AUTO) begin
          next_state = ST_RUN;
        end else begin
          next_state = ST_INTERLOCK;
        end
      end
      ST_HOLD: begin
        next_timer = timer + 28'h0000001;
        if (!start_in && (timer < RELEASE_CYCLES[27:0])) begin
          // early release accepts the reduced chain as the new size
          if (seg_lost || seg_short) begin
            next_seg_lost = 1'b0;
            next_cfg.seg_count = seg_count_in;
            next_code = `CODE_NONE;
          end
          next_state = ST_POWER;
        end else if (timer >= FLASH_CYCLES[27:0] - 28'h0000001) begin
          next_state = ST_POWER;
        end
      end
      ST_RUN: begin
        if (!zone_ok) begin
          next_state = ST_STOP;
        end
      end
      ST_STOP: begin
        if (do_program && cfg.blank_en && !span_err) begin
          next_pattern = beams_blocked_in;
          next_pat_valid = 1'b1;
        end else if (zone_ok && cfg.mode == MODE_RESTART_ILK) begin
          next_state = ST_INTERLOCK;
        end else if (zone_ok) begin
          next_state = ST_RUN;
        end
      end
      ST_INTERLOCK: begin
        if (!zone_ok) begin
          next_state = ST_STOP;
        end else if (start_release) begin
          next_state = ST_RUN;
        end
      end
      ST_CONFIG: begin
        if (do_program && cfg.blank_en && !span_err) begin
          next_pattern = beams_blocked_in;
          next_pat_valid = 1'b1;
          next_prog_flash = 1'b1;
        end else if (do_finish) begin
          next_state = ST_POWER;
        end
      end
      default: begin
        next_state = ST_ALARM;
      end
    endcase
    // saving a configuration
    if (wr_config) begin
      next_cfg = wr_cfg;
      if (!wr_cfg.blank_en) begin
        next_pattern = '0;
        next_pat_valid = 1'b0;
      end else if (!cfg.blank_en && state != ST_ALARM) begin
        next_state = ST_CONFIG;
      end
      if (state == ST_ALARM && code == `CODE_REDUCED && cfg_loaded &&
          wr_cfg.seg_count == seg_count_in) begin
        next_seg_lost = 1'b0;
        next_code = `CODE_NONE;
        next_state = ST_POWER;
      end
      next_cfg_loaded = 1'b0;
    end
    // a lost segment while powered overrides everything else
    if (running && seg_short) begin
      next_state = ST_ALARM;
      next_code = `CODE_FLEX;
      next_seg_lost = 1'b1;
      next_cfg = cfg;
    end
  end

  // volatile control state, cleared on power-up
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      state <= ST_POWER;
      code <= `CODE_NONE;
      timer <= 28'h0000000;
      hold_seen <= 1'b0;
      cfg_loaded <= 1'b0;
      prog_flash <= 1'b0;
      start_prev <= 1'b0;
    end else begin
      state <= next_state;
      code <= next_code;
      timer <= next_timer;
      hold_seen <= next_hold_seen;
      cfg_loaded <= next_cfg_loaded;
      prog_flash <= next_prog_flash;
      start_prev <= start_in;
    end
  end

  // stored configuration, pattern and loss flag persist over power cycles
  always_ff @(posedge core_clk_in) begin
    if (nv_init_in) begin
      cfg <= cfg_s'(`CFG_RESET);
      pattern <= '0;
      pat_valid <= 1'b0;
      seg_lost <= 1'b0;
    end else if (!sys_rst_in) begin
      cfg <= next_cfg;
      pattern <= next_pattern;
      pat_valid <= next_pat_valid;
      seg_lost <= next_seg_lost;
    end
  end

  // flash rate divider
  // blink toggles every BLINK_CYCLES cycles and restarts with each reset
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      blink_cnt <= 24'h000000;
      blink <= 1'b0;
    end else if (blink_cnt >= BLINK_CYCLES[23:0] - 24'h000001) begin
      blink_cnt <= 24'h000000;
      blink <= !blink;
    end else begin
      blink_cnt <= blink_cnt + 24'h000001;
    end
  end

  // registered outputs; they follow next_state so a fault drops the safety pair
  // on the same edge at which it is detected
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      rd_data_out <= 32'h00000000;
      safety_output_pair_out <= 2'b00;
      aux_out <= 1'b0;
      leds_out <= '0;
      beam_indicator_lamps_out <= '0;
      fault_code_out <= `CODE_NONE;
    end else begin
      rd_data_out <= rd_in ? rd_mux : 32'h00000000;
      safety_output_pair_out <= (next_state == ST_RUN) ? 2'b11 : 2'b00;
      aux_out <= (next_state == ST_RUN);
      leds_out.green <= (next_state == ST_RUN);
      leds_out.red <= (next_state == ST_HOLD || prog_flash) ? blink :
        (next_state != ST_RUN);
      leds_out.yellow <= (next_state == ST_ALARM || next_state == ST_HOLD) ? blink :
        (next_state == ST_INTERLOCK);
      leds_out.amber <= (next_state == ST_HOLD || prog_flash) ? blink :
        cfg.blank_en;
      if (next_state == ST_ALARM) begin
        beam_indicator_lamps_out <= {{(`BEAMS-8){1'b0}}, next_code};
      end else if (prog_flash && !blink) begin
        beam_indicator_lamps_out <= '0;
      end else begin
        beam_indicator_lamps_out <= beams_blocked_in;
      end
      fault_code_out <= next_code;
    end
  end
endmodule

/* File: tb/curtain_eval_assertions.sv */
// checker: port-level behaviour of the curtain evaluator
// assumes it is bound into curtain_eval; one clock, synchronous reset
`timescale 1ns/1ps
`include "curtain_defs.svh"
module curtain_eval_checker
  import curtain_pkg::*;
#(
  parameter int unsigned BLINK_CYCLES = 4
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic nv_init_in,
  input wire logic [2:0] seg_count_in,
  input wire logic [3:0][7:0] seg_beams_in,
  input wire logic start_in,
  input wire logic [1:0] safety_output_pair_out,
  input wire logic aux_out,
  input wire leds_s leds_out,
  input wire logic [`BEAMS-1:0] beam_indicator_lamps_out,
  input wire logic [7:0] fault_code_out
);
  localparam int FLASH_WIN = 2 * BLINK_CYCLES + 2;
  logic [9:0] total;
  logic size_bad;
  logic lost;
  assign total = 10'(seg_beams_in[0]) + 10'(seg_beams_in[1]) + 10'(seg_beams_in[2])
    + 10'(seg_beams_in[3]);
  assign size_bad = seg_beams_in[0] > 8'hb4 || seg_beams_in[1] > 8'h80
    || seg_beams_in[2] > 8'h80 || seg_beams_in[3] > 8'h80 || total > 10'h100
    || seg_count_in > 3'h4;
  // remembers a segment loss seen while powered
  always_ff @(posedge core_clk_in) begin
    if (nv_init_in || fault_code_out == 8'h64) begin
      lost <= 1'b0;
    end else if (fault_code_out == 8'h5f) begin
      lost <= 1'b1;
    end
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_up;
    $fell(sys_rst_in) && !start_in;
  endsequence
  sequence s_up_held;
    $fell(sys_rst_in) && start_in;
  endsequence
  property p_run;
    safety_output_pair_out == 2'b11 |-> leds_out.green && aux_out && fault_code_out == 8'h00;
  endproperty
  property p_pair;
    safety_output_pair_out[0] == safety_output_pair_out[1];
  endproperty
  property p_alarm;
    fault_code_out != 8'h00 |-> safety_output_pair_out == 2'b00 && !aux_out
      && beam_indicator_lamps_out[7:0] == fault_code_out;
  endproperty
  property p_flex_hold;
    fault_code_out == 8'h5f |=> fault_code_out == 8'h5f;
  endproperty
  property p_drop;
    safety_output_pair_out == 2'b11 && seg_count_in < $past(seg_count_in)
      |-> ##[1:2] fault_code_out == 8'h5f;
  endproperty
  property p_reduced;
    s_up ##0 (lost && !size_bad) |-> ##[1:3] fault_code_out == 8'h64;
  endproperty
  property p_size;
    s_up ##0 size_bad |-> ##[1:3] fault_code_out == 8'h01;
  endproperty
  property p_hold;
    s_up_held |-> ##[1:FLASH_WIN] leds_out.red && leds_out.yellow && leds_out.amber
      && safety_output_pair_out == 2'b00;
  endproperty
  a_run: assert property (p_run) else $error("run outputs inconsistent");
  a_pair: assert property (p_pair) else $error("safety pair split");
  a_alarm: assert property (p_alarm) else $error("alarm outputs wrong");
  a_flex_hold: assert property (p_flex_hold) else $error("flex fault left");
  a_drop: assert property (p_drop) else $error("no flex fault on drop");
  a_reduced: assert property (p_reduced) else $error("no reduced code");
  a_size: assert property (p_size) else $error("no size fault");
  a_hold: assert property (p_hold) else $error("no start-held flash");
endmodule

bind curtain_eval curtain_eval_checker #(.BLINK_CYCLES(BLINK_CYCLES)) i_curtain_eval_checker (
  .core_clk_in, .sys_rst_in, .nv_init_in, .seg_count_in, .seg_beams_in, .start_in,
  .safety_output_pair_out, .aux_out, .leds_out, .beam_indicator_lamps_out, .fault_code_out
);

/* File: tb/machine_side.sv */
// partner: machine control circuit with the operator start switch
// assumes tasks are called from the bench's single main process
`timescale 1ns/1ps
module machine_side (
  input wire logic core_clk_in,
  output logic start_out
);
  initial start_out = 1'b0;
  // press, hold for some cycles, release
  task automatic press(input int hold);
    @(posedge core_clk_in);
    start_out <= 1'b1;
    repeat (hold) @(posedge core_clk_in);
    start_out <= 1'b0;
  endtask
endmodule

/* File: tb/tb_top.sv */
// bench: segment checks, loss faults and fixed blanking of curtain_eval
// assumes the checker binds itself; flash and release counts are shortened
`timescale 1ns/1ps
`include "curtain_defs.svh"
module tb_top;
  import curtain_pkg::*;
  logic core_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic nv_init_in = 1'b1;
  logic [`BEAMS-1:0] beams_blocked_in = '0;
  logic [2:0] seg_count_in = 3'h3;
  logic [3:0][7:0] seg_beams_in = {8'h00, 8'h28, 8'h3c, 8'h64};
  logic start_in;
  logic [3:0] addr_in = 4'h0;
  logic [31:0] wr_data_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [31:0] rd_data_out;
  logic [1:0] safety_output_pair_out;
  logic aux_out;
  leds_s leds_out;
  logic [`BEAMS-1:0] beam_indicator_lamps_out;
  logic [7:0] fault_code_out;
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [31:0] rnd = 32'h000169f6;
  logic [`BEAMS-1:0] pat;
  logic [63:0] flip [9] = '{64'h400, 64'h200, 64'h800, 64'h10000, 64'h100000, 64'h80000,
    64'h600000, 64'h100000000, 64'hb40000000};
  logic [8:0] ok = 9'b000100011;
  logic [7:0] sz_m [5] = '{8'hb5, 8'hb4, 8'hb4, 8'h64, 8'h64};
  logic [7:0] sz_s [5] = '{8'h00, 8'h4c, 8'h4d, 8'h81, 8'h14};
  logic [2:0] sz_c [5] = '{3'h1, 3'h2, 3'h2, 3'h2, 3'h5};

  curtain_eval #(.FLASH_CYCLES(300), .RELEASE_CYCLES(200), .BLINK_CYCLES(4)) i_curtain_eval (
    .core_clk_in, .sys_rst_in, .nv_init_in, .beams_blocked_in, .seg_count_in, .seg_beams_in,
    .start_in, .addr_in, .wr_data_in, .wr_in, .rd_in, .rd_data_out, .safety_output_pair_out,
    .aux_out, .leds_out, .beam_indicator_lamps_out, .fault_code_out
  );
  machine_side i_machine_side (.core_clk_in, .start_out(start_in));

  always #10 core_clk_in = ~core_clk_in;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] cfgw(input logic [2:0] n, input logic [1:0] m, input logic b);
    return {26'h0, n, m, b};
  endfunction
  function automatic logic [7:0] size_code(input logic [7:0] m, s, input logic [2:0] n);
    return (m > 8'hb4 || s > 8'h80 || 10'(m) + 10'(s) > 10'h100 || n > 3'h4) ? 8'h01 : 8'h00;
  endfunction

  task automatic conclude;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_in <= 1'b1;
    @(posedge core_clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] m, e, input string what);
    @(posedge core_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge core_clk_in);
    rd_in <= 1'b0;
    #1 chk(what, e, rd_data_out & m);
  endtask
  task automatic put(input logic [`BEAMS-1:0] v);
    @(posedge core_clk_in);
    beams_blocked_in <= v;
  endtask
  task automatic pwr(input int n);
    @(posedge core_clk_in);
    sys_rst_in <= 1'b1;
    repeat (n) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
  endtask
  task automatic expect_out(input logic [1:0] pair, input logic [7:0] code);
    #1;
    for (int i = 0; i < 30 && (safety_output_pair_out !== pair || fault_code_out !== code); i++)
    begin
      @(posedge core_clk_in);
      #1;
    end
    chk("safety", 32'(pair), 32'(safety_output_pair_out));
    chk("fault", 32'(code), 32'(fault_code_out));
  endtask

  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      conclude();
    end
  end

  initial begin
    repeat (6) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    nv_init_in <= 1'b0;
    expect_out(2'b11, 8'h00);
    rchk(4'hc, 32'h173ff, 32'h30c8, "segments");
    rchk(4'h2, 32'hffffffff, 32'h0, "unmapped");
    wr(4'h0, cfgw(3'h3, 2'h0, 1'b0));
    rchk(4'h0, 32'h3f, cfgw(3'h3, 2'h0, 1'b0), "config");
    repeat (4) begin
      rnd = lfsr(rnd);
      pat = '0;
      pat[rnd % 200] = 1'b1;
      put(pat);
      @(posedge core_clk_in);
      #1 chk("stop", 32'h0, 32'(safety_output_pair_out));
      put('0);
      expect_out(2'b11, 8'h00);
    end
    wr(4'h0, cfgw(3'h3, 2'h0, 1'b1));
    rchk(4'h8, 32'h7, 32'h5, "state");
    pat = '0;
    pat[13:10] = 4'hf;
    pat[20] = 1'b1;
    pat[24:23] = 2'h3;
    pat[31:30] = 2'h3;
    pat[34:33] = 2'h3;
    put(pat);
    wr(4'h4, 32'h1);
    wr(4'h4, 32'h2);
    expect_out(2'b11, 8'h00);
    rchk(4'h8, 32'h20000, 32'h20000, "stored");
    for (int i = 0; i < 9; i++) begin
      put(pat ^ {192'h0, flip[i]});
      @(posedge core_clk_in);
      #1 chk("blank", 32'({2{ok[i]}}), 32'(safety_output_pair_out));
      put(pat);
      expect_out(2'b11, 8'h00);
    end
    for (int m = 0; m < 4; m++) begin
      wr(4'h0, cfgw(3'h3, m[1:0], 1'b1));
      pwr(2);
      if (m != 0) begin
        expect_out(2'b00, 8'h00);
        rchk(4'h8, 32'h7, 32'h2, "interlock");
        i_machine_side.press(2);
      end
      expect_out(2'b11, 8'h00);
    end
    wr(4'h0, cfgw(3'h3, 2'h0, 1'b0));
    rchk(4'h8, 32'h20000, 32'h0, "stored");
    expect_out(2'b00, 8'h00);
    put('0);
    expect_out(2'b11, 8'h00);
    @(posedge core_clk_in);
    seg_count_in <= 3'h2;
    seg_beams_in[2] <= 8'h00;
    expect_out(2'b00, 8'h5f);
    chk("lamps", 32'h5f, 32'(beam_indicator_lamps_out[7:0]));
    pwr(2);
    expect_out(2'b00, 8'h64);
    rchk(4'h0, 32'h3f, cfgw(3'h3, 2'h0, 1'b0), "config");
    wr(4'h0, cfgw(3'h2, 2'h0, 1'b0));
    expect_out(2'b11, 8'h00);
    @(posedge core_clk_in);
    sys_rst_in <= 1'b1;
    seg_count_in <= 3'h1;
    seg_beams_in[1] <= 8'h00;
    repeat (2) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    expect_out(2'b00, 8'h64);
    fork
      i_machine_side.press(100);
      pwr(6);
    join
    expect_out(2'b11, 8'h00);
    for (int k = 0; k < 5; k++) begin
      @(posedge core_clk_in);
      sys_rst_in <= 1'b1;
      seg_beams_in <= {16'h0, sz_s[k], sz_m[k]};
      seg_count_in <= sz_c[k];
      repeat (2) @(posedge core_clk_in);
      sys_rst_in <= 1'b0;
      expect_out(size_code(sz_m[k], sz_s[k], sz_c[k]) == 8'h00 ? 2'b11 : 2'b00,
        size_code(sz_m[k], sz_s[k], sz_c[k]));
    end
    conclude();
  end
endmodule
